// ===== design/ctcr_consts.svh
/*
 * Constants of the coherence trace control register: instruction code, debug segment offset,
 * field positions, reset values and the minimum revisions for the memory map and read-only variant.
 * Assumes inclusion by its bare name from the package and the register module.
 */
`ifndef CTCR_CONSTS_SVH
`define CTCR_CONSTS_SVH

`define CTCR_TAP_OPCODE       5'h15
`define CTCR_SEG_OFFSET       16'h3018
`define CTCR_REV_MMIO_MIN     8'h60
`define CTCR_REV_RO_MIN       8'h50
`define CTCR_BIT_WB           7
`define CTCR_BIT_STALL        5
`define CTCR_LEV_HI           4
`define CTCR_LEV_LO           3
`define CTCR_BIT_AE           2
`define CTCR_BIT_CORE_EN      1
`define CTCR_BIT_MASTER       0
`define CTCR_SRCID_HI         11
`define CTCR_SRCID_LO         8
`define CTCR_WRITE_MASK       32'h0000_00bf
`define CTCR_RESET_VALUE      32'h0000_0000
`define CTCR_LEV_NONE         2'h0
`define CTCR_LEV_STALL        2'h1

`endif

// ===== design/ctcr_pkg.sv
/*
 * Types shared by the coherence trace control register.
 * Assumes the constants header is on the include path.
 */
`include "ctcr_consts.svh"

package ctcr_pkg;

	// Decoded control fields as seen by the coherence manager.
	typedef struct packed
	{
		logic       writeback_trace_select;
		logic       stall_on_full;
		logic [1:0] trace_timing_level;
		logic       always_trace_select;
		logic       per_core_manager_trace_on;
		logic       manager_master_trace_on;
	} ctcr_ctrl_t;

	// One register access on the memory-mapped path.
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [15:0] offset;
		logic [31:0] wdata;
	} ctcr_req_t;

endpackage

// ===== design/ctcr_reg.sv
/*
 * Coherence trace control register of the trace control block.
 * Written by the debugger through a test-access-port instruction (shifted data delivered
 * here as a one-cycle update strobe already in this clock domain) and through the
 * memory-mapped debug segment. Gating signals from the coherence manager and other cores
 * arrive asynchronously and are synchronised here.
 */
//Contract
//- Test-access-port instruction 0x15 loads the register.
//- From revision 6.00 the register is also mapped at debug offset 0x3018.
//- Non-coherent core at revision 5.00 or later: all fields read-only.
//- Bits 15:12 and 6 read zero; debugger writes zero.
//- Bit 7 passes writeback requests to trace; clear suppresses them; resets zero.
//- Bit 5 stalls manager on full trace FIFO until space returns.
//- Bits 4:3 select timing level: 00 none, 01 stall times; others reserved.
//- Bit 2 makes manager tracing always enabled; resets zero.
//- Bit 0 is master enable; zero disables, one needs other conditions; resets zero.
//- Effective enable is OR of all per-core enables and software trace-on.
`timescale 1ns/1ps
`include "ctcr_consts.svh"

module ctcr_reg
	import ctcr_pkg::*;
#(
	parameter int          NUM_CORES  = 4,
	parameter logic [7:0]  TRACE_REV  = 8'h60,
	parameter logic        COHERENT   = 1'b1,
	parameter logic [3:0]  SOURCE_ID  = 4'h0
)
(
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_arst_n,
	input  wire logic [4:0]           i_tap_instr,
	input  wire logic                 i_tap_update,
	input  wire logic [31:0]          i_tap_data,
	input  wire ctcr_req_t            i_mm_req,
	input  wire logic [NUM_CORES-1:0] i_other_core_on,
	input  wire logic                 i_software_trace_on,
	input  wire logic                 i_other_conditions,
	input  wire logic                 i_writeback_req,
	input  wire logic                 i_fifo_full,
	output logic [31:0]               o_tap_rdata,
	output logic [31:0]               o_mm_rdata,
	output logic                      o_mm_ack,
	output logic                      o_mm_err,
	output ctcr_ctrl_t                o_ctrl,
	output logic                      o_trace_enable,
	output logic                      o_writeback_trace,
	output logic                      o_manager_stall
);

	logic [31:0]          ctl;
	logic [31:0]          next_ctl;
	logic [NUM_CORES+3:0] sync1;
	logic [NUM_CORES+3:0] sync2;
	logic                 mm_hit;
	logic                 tap_wr;
	logic                 mm_wr;
	logic                 writable;
	logic                 eff_on;
	logic [31:0]          rd_value;
	logic [31:0]          next_mm_rdata;
	logic                 next_mm_ack;
	logic                 next_mm_err;
	logic                 next_en;
	logic                 next_wb;
	logic                 next_stall;

	// Two-flop synchronisers for the asynchronous gating and status inputs.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {i_fifo_full, i_writeback_req, i_other_conditions, i_software_trace_on, i_other_core_on};
			sync2 <= sync1;
		end
	end

	// Decode of both access paths; the memory map exists only from revision 6.00.
	assign writable = !(!COHERENT && TRACE_REV >= `CTCR_REV_RO_MIN);
	assign tap_wr   = i_tap_update && i_tap_instr == `CTCR_TAP_OPCODE;
	assign mm_hit   = i_mm_req.valid && TRACE_REV >= `CTCR_REV_MMIO_MIN
		&& i_mm_req.offset == `CTCR_SEG_OFFSET;
	assign mm_wr    = mm_hit && i_mm_req.write;

	// Next register value; the memory-mapped write wins a same-cycle tie. Reserved bits are
	// masked so that a careless debugger cannot make them read back nonzero.
	always_comb
	begin
		next_ctl = ctl;
		if (writable && mm_wr)
			next_ctl = i_mm_req.wdata & `CTCR_WRITE_MASK;
		else if (writable && tap_wr)
			next_ctl = i_tap_data & `CTCR_WRITE_MASK;
	end

	// Read value: source identifier is fixed, reserved and implementation bits read zero.
	always_comb
	begin
		rd_value = ctl;
		rd_value[`CTCR_SRCID_HI:`CTCR_SRCID_LO] = SOURCE_ID;
	end

	// Effective enable: own bit ORed with other cores and software, then gated by master.
	assign eff_on = ctl[`CTCR_BIT_CORE_EN] || (|sync2[NUM_CORES-1:0]) || sync2[NUM_CORES];

	// Output next values, all registered so the manager sees clean levels.
	always_comb
	begin
		next_en       = ctl[`CTCR_BIT_MASTER] && (ctl[`CTCR_BIT_AE] || (eff_on && sync2[NUM_CORES+1]));
		next_wb       = next_en && ctl[`CTCR_BIT_WB] && sync2[NUM_CORES+2];
		next_stall    = next_en && ctl[`CTCR_BIT_STALL] && sync2[NUM_CORES+3];
		next_mm_ack   = i_mm_req.valid;
		next_mm_err   = i_mm_req.valid && !mm_hit;
		next_mm_rdata = (mm_hit && !i_mm_req.write) ? rd_value : 32'h0000_0000;
	end

	// Register state and registered outputs.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ctl               <= `CTCR_RESET_VALUE;
			o_tap_rdata       <= 32'h0000_0000;
			o_mm_rdata        <= 32'h0000_0000;
			o_mm_ack          <= 1'b0;
			o_mm_err          <= 1'b0;
			o_ctrl            <= '0;
			o_trace_enable    <= 1'b0;
			o_writeback_trace <= 1'b0;
			o_manager_stall   <= 1'b0;
		end
		else
		begin
			ctl               <= next_ctl;
			o_tap_rdata       <= rd_value;
			o_mm_rdata        <= next_mm_rdata;
			o_mm_ack          <= next_mm_ack;
			o_mm_err          <= next_mm_err;
			o_ctrl            <= {ctl[`CTCR_BIT_WB], ctl[`CTCR_BIT_STALL], ctl[`CTCR_LEV_HI:`CTCR_LEV_LO],
				ctl[`CTCR_BIT_AE], ctl[`CTCR_BIT_CORE_EN], ctl[`CTCR_BIT_MASTER]};
			o_trace_enable    <= next_en;
			o_writeback_trace <= next_wb;
			o_manager_stall   <= next_stall;
		end
	end

	// Checks on what the block drives. The synchronised copies are used in the antecedents so
	// that each property lines up with the cycle in which the logic itself saw the input; the
	// raw pins would lead the registered outputs by three cycles and give false failures.

	// Loads through both access paths, memory-mapped responses and the read-only variant.
	AST_TAP_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		writable && tap_wr && !mm_wr |=> ctl == ($past(i_tap_data) & `CTCR_WRITE_MASK))
		else $error("tap load failed");
	AST_TAP_OTHER: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		i_tap_update && i_tap_instr != `CTCR_TAP_OPCODE && !mm_wr |=> $stable(ctl))
		else $error("foreign instruction changed register");
	AST_MM_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		writable && mm_wr |=> ctl == ($past(i_mm_req.wdata) & `CTCR_WRITE_MASK))
		else $error("memory-mapped load failed");
	AST_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		i_mm_req.valid |=> o_mm_ack)
		else $error("request not acknowledged");
	AST_ERR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		i_mm_req.valid && !mm_hit |=> o_mm_err)
		else $error("unmapped access not flagged");
	AST_RDZERO: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		i_mm_req.valid && (i_mm_req.write || !mm_hit) |=> o_mm_rdata == 32'h0000_0000)
		else $error("read data outside a mapped read");
	AST_RO: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		!writable |=> $stable(ctl))
		else $error("read-only register changed");

	// Read-back of reserved and fixed fields.
	AST_RSVD: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_mm_rdata[15:12] == 4'h0 && o_mm_rdata[6] == 1'b0 && o_tap_rdata[6] == 1'b0)
		else $error("reserved bits nonzero");
	AST_RSVD_TAP: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		$past(i_arst_n) |-> o_tap_rdata[15:12] == 4'h0
			&& o_tap_rdata[`CTCR_SRCID_HI:`CTCR_SRCID_LO] == SOURCE_ID)
		else $error("fixed read-back fields wrong");

	// Field forwarding and the enable chain.
	AST_WB: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		!ctl[`CTCR_BIT_WB] |=> !o_writeback_trace)
		else $error("writeback traced while suppressed");
	AST_WB_REQ: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_writeback_trace |-> $past(sync2[NUM_CORES+2]) && o_trace_enable)
		else $error("writeback traced without request");
	AST_CTRL_WB: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		1'b1 |=> o_ctrl.writeback_trace_select == $past(ctl[`CTCR_BIT_WB]))
		else $error("writeback select not forwarded");
	AST_STALL: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_manager_stall |-> $past(sync2[NUM_CORES+3]) && $past(ctl[`CTCR_BIT_STALL]))
		else $error("stall without full fifo");
	AST_STALL_EN: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_manager_stall |-> o_trace_enable)
		else $error("stall while tracing disabled");
	AST_LEV: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		1'b1 |=> o_ctrl.trace_timing_level == $past(ctl[`CTCR_LEV_HI:`CTCR_LEV_LO]))
		else $error("level not forwarded");
	AST_AE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		ctl[`CTCR_BIT_AE] && ctl[`CTCR_BIT_MASTER] |=> o_trace_enable)
		else $error("always-enable ignored");
	AST_CORE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		ctl[1:0] == 2'h3 && sync2[NUM_CORES+1] |=> o_trace_enable)
		else $error("own enable ignored");
	AST_SW: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		ctl[`CTCR_BIT_MASTER] && sync2[NUM_CORES] && sync2[NUM_CORES+1] |=> o_trace_enable)
		else $error("software enable ignored");
	AST_OTHERS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		ctl[`CTCR_BIT_MASTER] && (|sync2[NUM_CORES-1:0]) && sync2[NUM_CORES+1] |=> o_trace_enable)
		else $error("other core enable ignored");
	AST_MASTER: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		!ctl[`CTCR_BIT_MASTER] |=> !o_trace_enable)
		else $error("traced with master off");
	AST_NO_COND: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		ctl[`CTCR_BIT_MASTER] && !ctl[`CTCR_BIT_AE] && !sync2[NUM_CORES+1] |=> !o_trace_enable)
		else $error("traced with other conditions false");

endmodule

// ===== sim/ctcr_dbg_model.sv
/* Debugger model on the test-access-port side of the trace control register.
   Assumes one bench thread calls tap_load at a time. */
`timescale 1ns/1ps
module ctcr_dbg_model (
	input  wire logic   i_clk_sys,
	output logic [4:0]  o_tap_instr,
	output logic        o_tap_update,
	output logic [31:0] o_tap_data
);
	// Idle on an unrelated code so no load can fire by accident.
	initial
	begin
		o_tap_instr = 5'h1f;
		o_tap_update = 1'b0;
		o_tap_data = 32'h0;
	end
	// One strobe carries the whole word; data is scrambled once released.
	task automatic tap_load(input logic [4:0] op, input logic [31:0] d);
		@(posedge i_clk_sys);
		o_tap_instr <= op;
		o_tap_data <= d;
		o_tap_update <= 1'b1;
		@(posedge i_clk_sys);
		o_tap_update <= 1'b0;
		o_tap_data <= ~d;
	endtask
endmodule

// ===== sim/coherence_trace_control_reg_tb.sv
/* Self-checking bench for the coherence trace control register.
   Assumes default design parameters and the debugger model on the TAP side. */
`timescale 1ns/1ps
module coherence_trace_control_reg_tb;
	import ctcr_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sw = 1'b0;
	logic        cond = 1'b0;
	logic        wbr = 1'b0;
	logic        full = 1'b0;
	logic [3:0]  others = 4'h0;
	logic [4:0]  instr;
	logic        upd;
	logic [31:0] tdata;
	logic [31:0] trd;
	logic [31:0] trd_ro;
	logic [31:0] mrd;
	ctcr_req_t   mm = '0;
	ctcr_ctrl_t  ctrl;
	logic        ack;
	logic        err;
	logic        ten;
	logic        wbt;
	logic        stl;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #5 clk = ~clk;
	ctcr_dbg_model u_ctcr_dbg_model (.i_clk_sys(clk), .o_tap_instr(instr), .o_tap_update(upd), .o_tap_data(tdata));
	ctcr_reg u_ctcr_reg (.i_clk_sys(clk), .i_arst_n(rst_n), .i_tap_instr(instr), .i_tap_update(upd),
		.i_tap_data(tdata), .i_mm_req(mm), .i_other_core_on(others), .i_software_trace_on(sw),
		.i_other_conditions(cond), .i_writeback_req(wbr), .i_fifo_full(full), .o_tap_rdata(trd),
		.o_mm_rdata(mrd), .o_mm_ack(ack), .o_mm_err(err), .o_ctrl(ctrl), .o_trace_enable(ten),
		.o_writeback_trace(wbt), .o_manager_stall(stl));
	// A non-coherent copy sees the same writes and must never change; its source identifier
	// is set apart from zero so that the four-bit field shows in the read-back.
	ctcr_reg #(.COHERENT(1'b0), .SOURCE_ID(4'hc)) u_ctcr_reg_ro (.i_clk_sys(clk), .i_arst_n(rst_n),
		.i_tap_instr(instr), .i_tap_update(upd), .i_tap_data(tdata), .i_mm_req(mm), .i_other_core_on(others),
		.i_software_trace_on(sw), .i_other_conditions(cond), .i_writeback_req(wbr), .i_fifo_full(full),
		.o_tap_rdata(trd_ro), .o_mm_rdata(), .o_mm_ack(), .o_mm_err(), .o_ctrl(), .o_trace_enable(),
		.o_writeback_trace(), .o_manager_stall());
	// Compare and count.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		if (seen !== exp)
			fail_count++;
	endtask
	// Waits end just after an edge so outputs have settled.
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One memory-mapped access; the answer stands for one cycle only.
	task automatic mm_acc(input logic w, input logic [15:0] off, input logic [31:0] d, input logic e);
		@(posedge clk);
		mm <= '{1'b1, w, off, d};
		@(posedge clk);
		mm <= '0;
		#1;
		chk({ack, err}, {1'b1, e});
	endtask
	// Write the register, let the synchronisers settle, check the three enables.
	task automatic en_case(input logic [31:0] d, input logic c, input logic [2:0] e);
		@(posedge clk);
		cond <= c;
		mm_acc(1'b1, 16'h3018, d, 1'b0);
		wait_n(5);
		chk({ten, wbt, stl}, e);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Cut a hang short; the tests need well under a thousand cycles.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wait_n(2);
		chk(trd, 32'h0);
		chk(32'(ctrl), 32'h0);
		chk(trd_ro, 32'h0000_0c00);
		// Stall and level go in first; the second load then writes ones into bits 31:16 and the source identifier field.
		u_ctcr_dbg_model.tap_load(5'h15, 32'h0000_0038);
		wait_n(3);
		chk(32'(ctrl), 32'h0000_0038);
		u_ctcr_dbg_model.tap_load(5'h15, 32'hffff_0fbf);
		wait_n(3);
		chk(trd, 32'h0000_00bf);
		chk(32'(ctrl), 32'h0000_007f);
		chk(trd_ro, 32'h0000_0c00);
		u_ctcr_dbg_model.tap_load(5'h16, 32'h0);
		wait_n(3);
		chk(trd, 32'h0000_00bf);
		$display("Test tap done");
		mm_acc(1'b1, 16'h3018, 32'h0000_0028, 1'b0);
		mm_acc(1'b0, 16'h3018, 32'h0, 1'b0);
		chk(mrd, 32'h0000_0028);
		chk(32'(ctrl), 32'h0000_0028);
		mm_acc(1'b0, 16'h3020, 32'h0, 1'b1);
		chk(mrd, 32'h0);
		$display("Test mmio done");
		@(posedge clk);
		wbr <= 1'b1;
		full <= 1'b1;
		// Every mix of other core 0, software on and the remaining conditions.
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			others <= {3'h0, i[2]};
			sw <= i[1];
			en_case(32'h0000_00a9, i[0], {3{(i[2] | i[1]) & i[0]}});
		end
		@(posedge clk);
		others <= 4'h0;
		sw <= 1'b0;
		en_case(32'h0000_0023, 1'b1, 3'h5);
		en_case(32'h0000_0005, 1'b0, 3'h4);
		en_case(32'h0000_0006, 1'b1, 3'h0);
		// With no request pending and room in the FIFO neither gated output may rise.
		@(posedge clk);
		wbr <= 1'b0;
		full <= 1'b0;
		en_case(32'h0000_00a7, 1'b0, 3'h4);
		$display("Test enable done");
		// A reset in mid-run must clear every field that was set.
		@(posedge clk);
		rst_n <= 1'b0;
		wait_n(2);
		@(posedge clk);
		rst_n <= 1'b1;
		wait_n(2);
		chk(32'(ctrl), 32'h0);
		chk({ten, wbt, stl}, 3'h0);
		chk(trd, 32'h0);
		$display("Test reset done");
		wrap_up();
	end
endmodule
